// ---- hw/isp_bus_if.sv ----
// Two-wire bus between host end and device end, wired-AND with pull-up
interface isp_bus_if;
  logic scl;
  logic sda;
  logic dev_scl_out;
  logic dev_scl_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic host_scl_out;
  logic host_scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;

  // A line reads low when either end enables a low drive
  assign scl = (dev_scl_oe_n | dev_scl_out) & (host_scl_oe_n | host_scl_out);
  assign sda = (dev_sda_oe_n | dev_sda_out) & (host_sda_oe_n | host_sda_out);

  modport dev (
    input scl,
    input sda,
    output dev_scl_out,
    output dev_scl_oe_n,
    output dev_sda_out,
    output dev_sda_oe_n
  );

  modport host (
    input scl,
    input sda,
    output host_scl_out,
    output host_scl_oe_n,
    output host_sda_out,
    output host_sda_oe_n
  );
endinterface : isp_bus_if

// ---- hw/isp_dev.sv ----
// Device end of the I2C register port: slave engine on the link clock
// Overview of operation
// - Asleep NACK: master sends STOP, then retries
// - Woken device acknowledges its address on retry
// - Master may chain transfers, ends with STOP
// - Slave only, bus at most 400 kHz
// - Busy device holds SCL low; master waits
// - Multi-master: prefer repeated START over STOP
// - Clock stretch bounded to 100 us
// - Stretch after ACK or after START
// - Write address, then register byte loads pointer
// - Pointer advances by one per data byte
// - Pointer held across repeated START and across STOP
// - Read restarts and returns data from pointer
// - Auto-increment everywhere except designated registers
// - Master writes zero to reserved bits
// - General call write of 0x06 resets
// - General call reset restores default slave address
// - Master ACKs wanted bytes, NACKs last, STOPs
// - Direction bit: zero write, one read
// - In halt, only own address wakes
module isp_dev (
  input wire logic LINK_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  isp_bus_if.dev BUS,
  input wire logic BUSY_IN,
  input wire logic SLEEP_IN,
  input wire logic NOINC_IN,
  input wire logic SADDR_WR_IN,
  input wire logic [6:0] SADDR_IN,
  input wire logic [7:0] RD_DATA_IN,
  output logic [7:0] PTR_OUT,
  output logic WR_STB_OUT,
  output logic [7:0] WR_DATA_OUT,
  output logic RD_STB_OUT,
  output logic GC_RESET_OUT,
  output logic ACTIVE_OUT,
  output logic [6:0] SADDR_OUT
);
  import isp_pkg::*;

  typedef struct packed {
    isp_dev_st_e st;
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_p;
    logic sda_p;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [6:0] saddr;
    logic rw;
    logic gc;
    logic gc_ok;
    logic gc_seen;
    logic first;
    logic inc_pend;
    logic ack_got;
    logic asleep;
    logic sda_low;
    logic scl_low;
    logic [11:0] str_cnt;
    logic wr_stb;
    logic [7:0] wr_data;
    logic rd_stb;
    logic [7:0] rd_data;
    logic gc_rst;
  } isp_dev_s;

  localparam isp_dev_s DEV_RESET = '{
    st: DS_IDLE,
    scl_sy: 2'h3,
    sda_sy: 2'h3,
    scl_p: 1'b1,
    sda_p: 1'b1,
    saddr: SADDR_DEFAULT,
    default: '0
  };

  isp_dev_s q;
  isp_dev_s n;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic own;
  logic gcall;

  // Exception registers keep the pointer still so a FIFO can be drained
  function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic hold);
    next_ptr = p + {7'h00, ~hold};
  endfunction : next_ptr

  //////////////////////////////////////////////////////////////////////////////
  // Only the second synchroniser stage feeds the edge and condition detectors
  assign scl = q.scl_sy[1];
  assign sda = q.sda_sy[1];
  assign rise = scl & ~q.scl_p;
  assign fall = ~scl & q.scl_p;
  assign start = scl & q.scl_p & ~sda & q.sda_p;
  assign stop = scl & q.scl_p & sda & ~q.sda_p;
  assign own = (q.sh[7:1] == q.saddr);
  assign gcall = (q.sh[7:1] == GC_ADDR) && (q.sh[0] == DIR_WRITE);

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    n.wr_stb = 1'b0;
    n.rd_stb = 1'b0;
    n.gc_rst = 1'b0;
    n.scl_sy = {q.scl_sy[0], BUS.scl};
    n.sda_sy = {q.sda_sy[0], BUS.sda};
    n.scl_p = scl;
    n.sda_p = sda;
    if (q.rd_stb) begin
      n.rd_data = RD_DATA_IN;
    end
    if (SADDR_WR_IN) begin
      n.saddr = SADDR_IN;
    end
    if (SLEEP_IN) begin
      n.asleep = 1'b1;
    end
    // Busy never holds the bus past the bound
    if (q.scl_low) begin
      n.str_cnt = q.str_cnt + 12'h001;
      if (!BUSY_IN || (q.str_cnt == STRETCH_MAX_CYC - 12'h001)) begin
        n.scl_low = 1'b0;
      end
    end
    if (start) begin
      n.st = DS_ADDR;
      n.bitn = 4'h0;
      n.sda_low = 1'b0;
      n.scl_low = BUSY_IN;
      n.str_cnt = 12'h000;
    end else if (stop) begin
      n.st = DS_IDLE;
      n.sda_low = 1'b0;
      n.scl_low = 1'b0;
      n.first = 1'b0;
      n.inc_pend = 1'b0;
      n.gc = 1'b0;
      if (q.gc && q.gc_ok) begin
        n.gc_rst = 1'b1;
        n.saddr = SADDR_DEFAULT;
      end
    end else begin
      unique case (q.st)
        DS_IDLE: begin
        end
        DS_ADDR, DS_RX: begin
          if (rise) begin
            n.sh = {q.sh[6:0], sda};
            n.bitn = q.bitn + 4'h1;
          end else if (fall && (q.bitn == BYTE_LAST_BIT)) begin
            if (q.st == DS_ADDR) begin
              n.rw = q.sh[0];
              n.gc = gcall;
              n.gc_ok = 1'b0;
              n.gc_seen = 1'b0;
              // Waking costs the first attempt: the master must retry
              if (own && q.asleep) begin
                n.asleep = SLEEP_IN;
                n.st = DS_IDLE;
              end else if (own || (gcall && !q.asleep)) begin
                n.sda_low = 1'b1;
                n.st = DS_ACK_A;
                n.rd_stb = own & q.sh[0];
              end else begin
                n.st = DS_IDLE;
              end
            end else begin
              n.sda_low = 1'b1;
              n.st = DS_ACK_RX;
              if (q.gc) begin
                n.gc_ok = (q.sh == GC_RESET_DATA) && !q.gc_seen;
                n.gc_seen = 1'b1;
              end else if (q.first) begin
                n.ptr = q.sh;
                n.first = 1'b0;
              end else begin
                n.wr_stb = 1'b1;
                n.wr_data = q.sh;
                n.inc_pend = 1'b1;
              end
            end
          end
        end
        DS_ACK_A: begin
          if (fall) begin
            n.bitn = 4'h0;
            n.scl_low = BUSY_IN;
            n.str_cnt = 12'h000;
            if (q.rw) begin
              n.st = DS_TX;
              n.sh = q.rd_data;
              n.sda_low = ~q.rd_data[7];
            end else begin
              n.st = DS_RX;
              n.sda_low = 1'b0;
              n.first = 1'b1;
            end
          end
        end
        DS_ACK_RX: begin
          if (fall) begin
            n.sda_low = 1'b0;
            n.bitn = 4'h0;
            n.st = DS_RX;
            n.scl_low = BUSY_IN;
            n.str_cnt = 12'h000;
            if (q.inc_pend) begin
              n.ptr = next_ptr(q.ptr, NOINC_IN);
              n.inc_pend = 1'b0;
            end
          end
        end
        DS_TX: begin
          if (rise) begin
            n.bitn = q.bitn + 4'h1;
          end else if (fall) begin
            if (q.bitn == BYTE_LAST_BIT) begin
              n.sda_low = 1'b0;
              n.st = DS_MACK;
            end else begin
              n.sh = {q.sh[6:0], 1'b0};
              n.sda_low = ~q.sh[6];
            end
          end
        end
        DS_MACK: begin
          if (rise) begin
            // The pointer advances even on the final NACKed byte
            n.ack_got = ~sda;
            n.ptr = next_ptr(q.ptr, NOINC_IN);
            n.rd_stb = ~sda;
          end else if (fall) begin
            if (q.ack_got) begin
              n.st = DS_TX;
              n.bitn = 4'h0;
              n.sh = q.rd_data;
              n.sda_low = ~q.rd_data[7];
              n.scl_low = BUSY_IN;
              n.str_cnt = 12'h000;
            end else begin
              n.st = DS_IDLE;
            end
          end
        end
        default: begin
          n.st = DS_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pointer survives repeated START; only the register byte after a write address reloads it
  always_ff @(posedge LINK_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      q <= DEV_RESET;
    end else if (CE_IN) begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign BUS.dev_scl_out = 1'b0;
  assign BUS.dev_scl_oe_n = ~q.scl_low;
  assign BUS.dev_sda_out = 1'b0;
  assign BUS.dev_sda_oe_n = ~q.sda_low;
  assign PTR_OUT = q.ptr;
  assign WR_STB_OUT = q.wr_stb;
  assign WR_DATA_OUT = q.wr_data;
  assign RD_STB_OUT = q.rd_stb;
  assign GC_RESET_OUT = q.gc_rst;
  assign ACTIVE_OUT = ~q.asleep;
  assign SADDR_OUT = q.saddr;

endmodule : isp_dev

// ---- hw/isp_host.sv ----
// Host end of the I2C register port: byte-level bus master on the system clock
module isp_host (
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  isp_bus_if.host BUS,
  input wire logic CMD_VALID_IN,
  output logic CMD_READY_OUT,
  input isp_pkg::isp_cmd_e CMD_IN,
  input wire logic [7:0] CMD_DATA_IN,
  input wire logic CMD_RW_IN,
  input wire logic CMD_LAST_IN,
  input wire logic [7:0] CMD_RSVD_IN,
  output logic RSP_VALID_OUT,
  output logic [7:0] RSP_DATA_OUT,
  output logic RSP_NACK_OUT,
  output logic BUS_HELD_OUT
);
  import isp_pkg::*;

  typedef struct packed {
    isp_host_st_e st;
    isp_cmd_e cmd;
    logic [1:0] ph;
    logic [3:0] tick;
    logic [3:0] bitn;
    logic [8:0] tx;
    logic [8:0] rx;
    logic [7:0] abyte;
    logic retry;
    logic again;
    logic held;
    logic scl_low;
    logic sda_low;
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
  } isp_host_s;

  localparam isp_host_s HOST_RESET = '{
    st: HS_IDLE,
    cmd: CMD_STOP,
    scl_sy: 2'h3,
    sda_sy: 2'h3,
    default: '0
  };

  isp_host_s q;
  isp_host_s n;
  logic scl;
  logic wait_high;
  logic step;
  logic [8:0] tx_new;

  assign scl = q.scl_sy[1];
  // A slave holding SCL low freezes the high phase until it lets go
  assign wait_high = (q.ph == 2'h1) && (q.st != HS_IDLE) && !scl;
  assign step = (q.tick == SCL_QTR_CYC - 4'h1) && !wait_high;
  // Reserved bits are forced to zero on every write
  assign tx_new = (CMD_IN == CMD_WRITE) ? {CMD_DATA_IN & ~CMD_RSVD_IN, 1'b1}
                                        : {8'hff, CMD_LAST_IN};

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    n.rsp_valid = 1'b0;
    n.scl_sy = {q.scl_sy[0], BUS.scl};
    n.sda_sy = {q.sda_sy[0], BUS.sda};
    if (q.st != HS_IDLE) begin
      n.tick = (step || wait_high) ? 4'h0 : q.tick + 4'h1;
      if (step) begin
        n.ph = q.ph + 2'h1;
      end
    end
    unique case (q.st)
      HS_IDLE: begin
        if (CMD_VALID_IN) begin
          n.cmd = CMD_IN;
          n.ph = 2'h0;
          n.tick = 4'h0;
          n.bitn = 4'h0;
          unique case (CMD_IN)
            CMD_ADDR: begin
              n.abyte = {CMD_DATA_IN[6:0], CMD_RW_IN};
              n.retry = 1'b0;
              n.sda_low = 1'b0;
              n.st = HS_START;
            end
            CMD_WRITE, CMD_READ: begin
              n.tx = tx_new;
              n.sda_low = ~tx_new[8];
              n.st = HS_BIT;
            end
            CMD_STOP: begin
              n.sda_low = 1'b1;
              n.st = HS_STOP;
            end
          endcase
        end
      end
      HS_START: begin
        if (step) begin
          unique case (q.ph)
            2'h0: n.scl_low = 1'b0;
            2'h1: n.sda_low = 1'b1;
            2'h2: n.scl_low = 1'b1;
            2'h3: begin
              n.held = 1'b1;
              n.st = HS_BIT;
              n.bitn = 4'h0;
              n.tx = {q.abyte, 1'b1};
              n.sda_low = ~q.abyte[7];
            end
          endcase
        end
      end
      HS_BIT: begin
        if (step) begin
          unique case (q.ph)
            2'h0: n.scl_low = 1'b0;
            2'h1: n.rx = {q.rx[7:0], q.sda_sy[1]};
            2'h2: n.scl_low = 1'b1;
            2'h3: begin
              if (q.bitn != BYTE_LAST_BIT) begin
                n.bitn = q.bitn + 4'h1;
                n.tx = {q.tx[7:0], 1'b1};
                n.sda_low = ~q.tx[7];
              end else if ((q.cmd == CMD_ADDR) && q.rx[0] && !q.retry) begin
                // Sleeping slave refused: STOP, then a fresh START
                n.retry = 1'b1;
                n.again = 1'b1;
                n.sda_low = 1'b1;
                n.st = HS_STOP;
              end else begin
                n.sda_low = 1'b0;
                n.rsp_valid = 1'b1;
                n.rsp_data = q.rx[8:1];
                n.rsp_nack = q.rx[0];
                n.st = HS_IDLE;
              end
            end
          endcase
        end
      end
      HS_STOP: begin
        if (step) begin
          unique case (q.ph)
            2'h0: n.scl_low = 1'b0;
            2'h1: n.sda_low = 1'b0;
            2'h2: begin
              n.held = 1'b0;
              n.ph = 2'h0;
              if (q.again) begin
                n.again = 1'b0;
                n.st = HS_START;
              end else begin
                n.rsp_valid = 1'b1;
                n.rsp_nack = 1'b0;
                n.st = HS_IDLE;
              end
            end
            2'h3: n.st = HS_IDLE;
          endcase
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      q <= HOST_RESET;
    end else if (CE_IN) begin
      q <= n;
    end
  end

  assign BUS.host_scl_out = 1'b0;
  assign BUS.host_scl_oe_n = ~q.scl_low;
  assign BUS.host_sda_out = 1'b0;
  assign BUS.host_sda_oe_n = ~q.sda_low;
  assign CMD_READY_OUT = (q.st == HS_IDLE);
  assign RSP_VALID_OUT = q.rsp_valid;
  assign RSP_DATA_OUT = q.rsp_data;
  assign RSP_NACK_OUT = q.rsp_nack;
  assign BUS_HELD_OUT = q.held;

endmodule : isp_host

// ---- hw/isp_pkg.sv ----
// Shared constants and types for the I2C register port, device end and host end
package isp_pkg;

  // Slave address in 7-bit form; 0x88 when shown with the direction bit
  localparam logic [6:0] SADDR_DEFAULT = 7'h44;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET_DATA = 8'h06;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h8;

  //////////////////////////////////////////////////////////////////////////////
  // Device side timing, link clock
  localparam int LINK_PERIOD_NS = 32;
  localparam int STRETCH_MAX_US = 100;
  // Longest time, rounds down
  localparam logic [11:0] STRETCH_MAX_CYC = 12'((STRETCH_MAX_US * 1000) / LINK_PERIOD_NS);

  //////////////////////////////////////////////////////////////////////////////
  // Host side timing, system clock
  localparam int SYS_PERIOD_NS = 50;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_QTR_NS = 1000000 / (SCL_MAX_KHZ * 4);
  // Least time, rounds up
  localparam logic [3:0] SCL_QTR_CYC = 4'((SCL_QTR_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_ADDR = 3'b001,
    DS_ACK_A = 3'b010,
    DS_RX = 3'b011,
    DS_ACK_RX = 3'b100,
    DS_TX = 3'b101,
    DS_MACK = 3'b110
  } isp_dev_st_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BIT = 2'b10,
    HS_STOP = 2'b11
  } isp_host_st_e;

  typedef enum logic [1:0] {
    CMD_ADDR = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_READ = 2'b10,
    CMD_STOP = 2'b11
  } isp_cmd_e;

endpackage : isp_pkg

// ---- verif/i2c_slave_register_port_test.sv ----
// Bench joining host end and device end over the two-wire bus
module i2c_slave_register_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import isp_pkg::*;
  // Reset starts high so its fall at time zero is a real edge for every process
  logic clk = 0, lclk = 0, rst_n = 1, busy = 0, sleep = 0, noinc_en = 0, sa_wr = 0;
  logic valid = 0, rw = 0, last = 0, rsp_v, rsp_n, ready, held, wstb, rstb, gc, act, rnack;
  logic [6:0] sa = 7'h21, sa_o;
  logic [7:0] cmd_d = 8'h00, rsvd = 8'h00, rsp_d, ptr, wdat, rdat;
  isp_cmd_e cmd_c = CMD_STOP;
  int mismatches = 0, cmp_count = 0, cycles = 0, gc_cnt = 0, rd_cnt = 0, t0;
  logic [15:0] wq[$];

  isp_bus_if bus ();
  isp_dev isp_dev_i (.LINK_CLK_IN(lclk), .ARST_N_IN(rst_n), .CE_IN(1'b1), .BUS(bus.dev),
    .BUSY_IN(busy), .SLEEP_IN(sleep), .NOINC_IN(noinc_en && ptr == 8'h30),
    .SADDR_WR_IN(sa_wr), .SADDR_IN(sa), .RD_DATA_IN(ptr ^ 8'h5a), .PTR_OUT(ptr),
    .WR_STB_OUT(wstb), .WR_DATA_OUT(wdat), .RD_STB_OUT(rstb), .GC_RESET_OUT(gc),
    .ACTIVE_OUT(act), .SADDR_OUT(sa_o));
  isp_host isp_host_i (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .CE_IN(1'b1), .BUS(bus.host),
    .CMD_VALID_IN(valid), .CMD_READY_OUT(ready), .CMD_IN(cmd_c), .CMD_DATA_IN(cmd_d),
    .CMD_RW_IN(rw), .CMD_LAST_IN(last), .CMD_RSVD_IN(rsvd), .RSP_VALID_OUT(rsp_v),
    .RSP_DATA_OUT(rsp_d), .RSP_NACK_OUT(rsp_n), .BUS_HELD_OUT(held));
  isp_chk isp_chk_i (.CLK_SYS_IN(clk), .LINK_CLK_IN(lclk), .ARST_N_IN(rst_n), .scl(bus.scl),
    .sda(bus.sda), .dev_scl_out(bus.dev_scl_out), .dev_scl_oe_n(bus.dev_scl_oe_n),
    .dev_sda_out(bus.dev_sda_out), .dev_sda_oe_n(bus.dev_sda_oe_n),
    .host_scl_out(bus.host_scl_out), .host_scl_oe_n(bus.host_scl_oe_n),
    .host_sda_out(bus.host_sda_out), .host_sda_oe_n(bus.host_sda_oe_n));

  always #25 clk = ~clk;
  // Odd offset keeps link edges off every system clock edge
  initial begin
    #7.3;
    forever #16 lclk = ~lclk;
  end

  always @(posedge lclk) begin
    if (wstb === 1'b1) wq.push_back({ptr, wdat});
    if (gc === 1'b1) gc_cnt++;
    if (rstb === 1'b1) rd_cnt++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      chk_bit("run within cycle limit", 1'b1, 1'b0);
      finish_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  // One command, one cycle of valid; the next may follow the response cycle
  task automatic cmd(input isp_cmd_e c, input logic [7:0] d, input logic r, input logic l,
                     input logic [7:0] m);
    int n;
    @(posedge clk);
    valid <= 1'b1;
    cmd_c <= c;
    cmd_d <= d;
    rw <= r;
    last <= l;
    rsvd <= m;
    @(posedge clk);
    valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_v !== 1'b1 && n < 8000);
    chk_bit("response", 1'b1, rsp_v);
    chk_bit("ready", 1'b1, ready);
    rdat = rsp_d;
    rnack = rsp_n;
  endtask : cmd

  task automatic exp_wr(input logic [15:0] e);
    logic [15:0] g;
    g = wq.size() ? wq.pop_front() : 16'hxxxx;
    chk("write addr", e[15:8], g[15:8]);
    chk("write data", e[7:0], g[7:0]);
  endtask : exp_wr

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    cmd(CMD_ADDR, {1'b0, SADDR_DEFAULT}, 1'b0, 1'b0, 8'h00);
    chk_bit("write address ack", 1'b0, rnack);
    chk_bit("bus held", 1'b1, held);
    cmd(CMD_WRITE, 8'haa, 1'b0, 1'b0, 8'h00);
    cmd(CMD_WRITE, 8'h01, 1'b0, 1'b0, 8'h00);
    cmd(CMD_WRITE, 8'h05, 1'b0, 1'b0, 8'h00);
    cmd(CMD_WRITE, 8'hff, 1'b0, 1'b0, 8'h81);
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
    chk_bit("bus released", 1'b0, held);
    exp_wr(16'haa01);
    exp_wr(16'hab05);
    exp_wr(16'hac7e);
    // Read after repeated start, running across the top of the map
    cmd(CMD_ADDR, {1'b0, SADDR_DEFAULT}, 1'b0, 1'b0, 8'h00);
    cmd(CMD_WRITE, 8'hfe, 1'b0, 1'b0, 8'h00);
    cmd(CMD_ADDR, {1'b0, SADDR_DEFAULT}, 1'b1, 1'b0, 8'h00);
    chk_bit("read address ack", 1'b0, rnack);
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_READ, 8'h00, 1'b0, i == 2, 8'h00);
      chk("read data", 8'(8'hfe + i) ^ 8'h5a, rdat);
    end
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
    // Address decode and two master ACKs fetch; the NACKed byte fetches nothing
    chk("read strobes", 8'h03, 8'(rd_cnt));
    // Register without increment
    @(posedge lclk) noinc_en <= 1'b1;
    cmd(CMD_ADDR, {1'b0, SADDR_DEFAULT}, 1'b0, 1'b0, 8'h00);
    cmd(CMD_WRITE, 8'h30, 1'b0, 1'b0, 8'h00);
    cmd(CMD_WRITE, 8'h11, 1'b0, 1'b0, 8'h00);
    cmd(CMD_WRITE, 8'h22, 1'b0, 1'b0, 8'h00);
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
    @(posedge lclk) noinc_en <= 1'b0;
    exp_wr(16'h3011);
    exp_wr(16'h3022);
    // Busy device: each stretch point runs to its time limit until busy drops before STOP
    @(posedge lclk) busy <= 1'b1;
    t0 = cycles;
    cmd(CMD_ADDR, {1'b0, SADDR_DEFAULT}, 1'b0, 1'b0, 8'h00);
    chk_bit("stretch seen", 1'b1, cycles - t0 > 1500);
    cmd(CMD_WRITE, 8'h40, 1'b0, 1'b0, 8'h00);
    cmd(CMD_WRITE, 8'h99, 1'b0, 1'b0, 8'h00);
    @(posedge lclk) busy <= 1'b0;
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
    exp_wr(16'h4099);
    // Asleep: foreign traffic ignored, own address wakes and is taken on retry
    @(posedge lclk) sleep <= 1'b1;
    @(posedge lclk) sleep <= 1'b0;
    repeat (4) @(posedge lclk);
    chk_bit("asleep", 1'b0, act);
    cmd(CMD_ADDR, 8'h21, 1'b0, 1'b0, 8'h00);
    chk_bit("foreign nack", 1'b1, rnack);
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
    chk_bit("still asleep", 1'b0, act);
    cmd(CMD_ADDR, {1'b0, SADDR_DEFAULT}, 1'b0, 1'b0, 8'h00);
    chk_bit("retry ack", 1'b0, rnack);
    chk_bit("awake", 1'b1, act);
    cmd(CMD_WRITE, 8'h50, 1'b0, 1'b0, 8'h00);
    cmd(CMD_WRITE, 8'h77, 1'b0, 1'b0, 8'h00);
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
    exp_wr(16'h5077);
    // New slave address; two-byte general call must not reset, one-byte must
    @(posedge lclk) sa_wr <= 1'b1;
    @(posedge lclk) sa_wr <= 1'b0;
    repeat (4) @(posedge lclk);
    cmd(CMD_ADDR, {1'b0, SADDR_DEFAULT}, 1'b0, 1'b0, 8'h00);
    chk_bit("old address nack", 1'b1, rnack);
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
    for (int k = 2; k > 0; k--) begin
      cmd(CMD_ADDR, {1'b0, GC_ADDR}, 1'b0, 1'b0, 8'h00);
      chk_bit("general call ack", 1'b0, rnack);
      repeat (k) cmd(CMD_WRITE, GC_RESET_DATA, 1'b0, 1'b0, 8'h00);
      cmd(CMD_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
      chk("reset count", 8'(2 - k), 8'(gc_cnt));
      chk("slave address", {1'b0, k == 2 ? sa : SADDR_DEFAULT}, {1'b0, sa_o});
    end
    cmd(CMD_ADDR, {1'b0, SADDR_DEFAULT}, 1'b0, 1'b0, 8'h00);
    chk_bit("default address ack", 1'b0, rnack);
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
    finish_test();
  end
endmodule : i2c_slave_register_port_test

// ---- verif/isp_chk.sv ----
// Concurrent checks on the two-wire bus between host end and device end
module isp_chk
  import isp_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic LINK_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_out,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic host_scl_out,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_out,
  input wire logic host_sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] str_q;
  logic [7:0] low_q;
  logic hoe_p_q;
  logic hwait_q;

  // Length of the current device stretch, in link cycles
  always_ff @(posedge LINK_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      str_q <= 12'h000;
    end else begin
      str_q <= dev_scl_oe_n ? 12'h000 : str_q + 12'h001;
    end
  end

  // Length of the current SCL low phase, saturating so it cannot wrap into a pass
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      low_q <= 8'h00;
    end else if (scl) begin
      low_q <= 8'h00;
    end else if (low_q != 8'hff) begin
      low_q <= low_q + 8'h01;
    end
  end

  // Host let go of SCL and the line stayed low since: a stretch it must wait out
  // A device pull after START while the host has SCL released is not such a wait
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      hoe_p_q <= 1'b1;
      hwait_q <= 1'b0;
    end else begin
      hoe_p_q <= host_scl_oe_n;
      hwait_q <= host_scl_oe_n && !scl && (hwait_q || !hoe_p_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_stretch_bound;
    @(posedge LINK_CLK_IN) disable iff (!ARST_N_IN) str_q <= STRETCH_MAX_CYC + 12'h002;
  endproperty
  a_stretch_bound: assert property (p_stretch_bound)
    else $error("device stretch too long");
  property p_dev_no_cond;
    @(posedge LINK_CLK_IN) disable iff (!ARST_N_IN) scl && $past(scl) |-> $stable(dev_sda_oe_n);
  endproperty
  a_dev_no_cond: assert property (p_dev_no_cond)
    else $error("device moved data while clock high");
  property p_dev_ack_slot;
    @(posedge LINK_CLK_IN) disable iff (!ARST_N_IN) $fell(dev_sda_oe_n) |-> !scl;
  endproperty
  a_dev_ack_slot: assert property (p_dev_ack_slot)
    else $error("device drove data outside a low clock phase");
  property p_stretch_point;
    @(posedge LINK_CLK_IN) disable iff (!ARST_N_IN) $fell(dev_scl_oe_n) |-> !scl || !sda;
  endproperty
  a_stretch_point: assert property (p_stretch_point)
    else $error("device stretch outside a stretch point");
  property p_host_wait;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
      host_scl_oe_n && !scl && (hwait_q || !hoe_p_q) |=> host_scl_oe_n;
  endproperty
  a_host_wait: assert property (p_host_wait)
    else $error("host pulled clock during stretch");
  property p_scl_low_min;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) $rose(scl) |-> low_q >= 8'h19;
  endproperty
  a_scl_low_min: assert property (p_scl_low_min)
    else $error("clock low phase too short");
  property p_scl_high_min;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) $rose(scl) |-> scl [*8];
  endproperty
  a_scl_high_min: assert property (p_scl_high_min)
    else $error("clock high phase too short");
  property p_open_drain;
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
      !(dev_scl_out | dev_sda_out | host_scl_out | host_sda_out);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("line driven high");

  c_stretch: cover property (@(posedge LINK_CLK_IN) disable iff (!ARST_N_IN) $fell(dev_scl_oe_n));
  c_ack: cover property (@(posedge LINK_CLK_IN) disable iff (!ARST_N_IN) $fell(dev_sda_oe_n));
  c_wait: cover property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN) host_scl_oe_n && !scl);
endmodule : isp_chk
